/* File: tape_ptr_map.svh */
/*
 * Constants for the pointer and status block: register locations, field
 * positions, reset values and the boot transfer figures.
 * Assumes inclusion by bare name from every design file that needs them.
 */
`ifndef TAPE_PTR_MAP_SVH
`define TAPE_PTR_MAP_SVH

// ****************************************
// Register locations (word index)
// ****************************************
`define PTR_LOW_IDX      2'h1
`define STATUS_IDX       2'h2

// ****************************************
// Pointer high byte fields
// ****************************************
`define EXT_BOOT_BIT     15
`define EXT_PTR_MSB      11
`define EXT_PTR_LSB      8
`define EXT_PTR_RESET    4'h0
`define DMA_ADDR_RESET   22'h000000

// ****************************************
// Boot transfer
// ****************************************
`define BOOT_START_ADDR  22'h000000
`define BOOT_BYTES       10'h200

// ****************************************
// Status word fields and message slots
// ****************************************
`define TCW_TMK_BIT      15
`define TCW_EOT_BIT      0
`define DEW_OVERRUN_BIT  15
`define DEW_HARD_BIT     1
`define DIW_BUSY_BIT     15
`define MSG_SLOT_FIRST   3'h4
`define MSG_SLOT_LAST    3'h6
`define UCODE_REV        6'h01    // Arbitrary revision code
`define WORD_RESET       16'h0000

`endif

/* File: tape_ptr_pkg.sv */
/*
 * Types shared by the pointer and status block.
 * Assumes nothing of its surroundings.
 */
package tape_ptr_pkg;
    typedef logic [15:0] word_t;
    typedef logic [21:0] bus_addr_t;
    typedef enum logic [3:0] {
        K_READ, K_WRITE, K_WTM, K_SPACE, K_SKIP_TM, K_REWIND,
        K_GET_STATUS, K_DRV_INIT, K_WRCHAR, K_OTHER
    } cmd_kind_t;
    typedef enum {CTL_IDLE, CTL_FETCH, CTL_DEPOSIT, CTL_BOOT} ctl_state_t;
endpackage

/* File: pin_sync.sv */
/*
 * Two-stage synchroniser bank for drive pins and jumpers.
 * Assumes sys_clk is the only clock; inputs are asynchronous levels.
 */
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                stage1[i]   <= 1'b0;
                sync_out[i] <= 1'b0;
            end else begin
                stage1[i]   <= async_in[i];
                sync_out[i] <= stage1[i];
            end
        end
    end
endmodule // pin_sync

/* File: status_deposit.sv */
/*
 * Emits the three status words to the message buffer, one per cycle.
 * Assumes start arrives only while idle.
 */
`timescale 1ns/1ps
`include "tape_ptr_map.svh"
module status_deposit (
    input  wire logic               sys_clk,
    input  wire logic               rst,
    input  wire logic               start,
    input  tape_ptr_pkg::word_t     w_cond,
    input  tape_ptr_pkg::word_t     w_err,
    input  tape_ptr_pkg::word_t     w_info,
    output logic                    msg_wr,
    output logic [2:0]              msg_slot,
    output tape_ptr_pkg::word_t     msg_data,
    output logic                    done
);
    import tape_ptr_pkg::*;

    logic  active;
    word_t hold_err;
    word_t hold_info;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            active    <= 1'b0;
            msg_wr    <= 1'b0;
            msg_slot  <= `MSG_SLOT_FIRST;
            msg_data  <= `WORD_RESET;
            hold_err  <= `WORD_RESET;
            hold_info <= `WORD_RESET;
            done      <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !active) begin
                active    <= 1'b1;
                msg_wr    <= 1'b1;
                msg_slot  <= `MSG_SLOT_FIRST;
                msg_data  <= w_cond;
                hold_err  <= w_err;
                hold_info <= w_info;
            end else if (active) begin
                if (msg_slot == `MSG_SLOT_LAST) begin
                    active <= 1'b0;
                    msg_wr <= 1'b0;
                    done   <= 1'b1;
                end else begin
                    msg_slot <= msg_slot + 3'h1;
                    msg_data <= (msg_slot == `MSG_SLOT_FIRST) ? hold_err : hold_info;
                end
            end
        end
    end
endmodule // status_deposit

/* File: tape_ptr_status.sv */
/*
 * Command pointer extension, boot request and the composition of the three
 * extended status words deposited at command completion.
 * Assumes the register port, command events and bus_init come from logic on
 * sys_clk; drive pins and jumpers are asynchronous and are synchronised here.
 */
`timescale 1ns/1ps
`include "tape_ptr_map.svh"

module tape_ptr_status (
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    input  wire logic                   bus_init,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_byte,
    input  wire logic                   reg_byte_hi,
    input  wire logic [1:0]             reg_addr,
    input  tape_ptr_pkg::word_t         reg_wdata,
    input  wire logic                   diag_ok,
    input  wire logic                   cmd_done,
    input  wire logic                   boot_done,
    input  wire logic                   boot_fail,
    input  tape_ptr_pkg::cmd_kind_t     cmd_kind,
    input  wire logic                   cmd_reverse,
    input  wire logic                   cmd_bad_code,
    input  wire logic [23:0]            cmd_addr,
    input  wire logic                   cmd_need_even,
    input  wire logic                   cmd_ie,
    input  wire logic                   cvc_pulse,
    input  wire logic                   let_enable,
    input  wire logic                   double_mark_stop,
    input  wire logic                   tm_detect,
    input  wire logic                   rec_detect,
    input  wire logic                   bot_hit,
    input  wire logic                   short_record,
    input  wire logic                   long_record,
    input  wire logic                   count_left,
    input  wire logic                   logical_end,
    input  wire logic                   buf_full,
    input  wire logic                   buf_empty,
    input  wire logic                   drive_byte,
    input  wire logic                   drive_req,
    input  wire logic                   last_rec_req,
    input  wire logic                   hard_error_evt,
    input  wire logic                   drive_busy_pin,
    input  wire logic                   rewinding_pin,
    input  wire logic                   online_pin,
    input  wire logic                   wr_protect_pin,
    input  wire logic                   bot_pin,
    input  wire logic                   eot_hole_pin,
    input  wire logic                   ext_features_pin,
    input  wire logic                   buf_enable_pin,
    output logic                        subsystem_ready,
    output logic                        write_refused,
    output tape_ptr_pkg::bus_addr_t     dma_address,
    output logic                        fetch_start,
    output logic                        boot_start,
    output logic [9:0]                  boot_length,
    output tape_ptr_pkg::word_t         tape_condition_word,
    output tape_ptr_pkg::word_t         drive_error_word,
    output tape_ptr_pkg::word_t         drive_info_word,
    output logic                        msg_wr,
    output logic [2:0]                  msg_slot,
    output tape_ptr_pkg::word_t         msg_data
);
    import tape_ptr_pkg::*;

    // ****************************************
    // Decode helpers
    // ****************************************
    function automatic logic word_wr_at(input logic wr, input logic bw, input logic [1:0] a,
                                        input logic [1:0] idx);
        return wr && !bw && (a == idx);
    endfunction

    function automatic logic is_write_kind(input cmd_kind_t k);
        return (k == K_WRITE) || (k == K_WTM);
    endfunction

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [7:0] pins_s;
    logic       s_busy, s_rew, s_onl, s_wlk, s_bot, s_eot, s_ext, s_bufen;

    pin_sync #(.WIDTH(8)) u_sync (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .async_in ({buf_enable_pin, ext_features_pin, eot_hole_pin, bot_pin,
                    wr_protect_pin, online_pin, rewinding_pin, drive_busy_pin}),
        .sync_out (pins_s)
    );
    assign {s_bufen, s_ext, s_eot, s_bot, s_wlk, s_onl, s_rew, s_busy} = pins_s;

    // ****************************************
    // Register port decode
    // ****************************************
    logic low_wr, high_wr, soft_init, take_cmd;
    logic [3:0] ptr_ext;
    logic       boot_req;
    ctl_state_t state;

    assign low_wr    = word_wr_at(reg_wr, reg_byte, reg_addr, `PTR_LOW_IDX);
    assign high_wr   = reg_wr && reg_byte && reg_byte_hi && (reg_addr == `STATUS_IDX);
    assign soft_init = bus_init || word_wr_at(reg_wr, reg_byte, reg_addr, `STATUS_IDX);
    assign take_cmd  = low_wr && subsystem_ready;

    // ****************************************
    // Pointer high byte
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (rst || soft_init) begin
            ptr_ext  <= `EXT_PTR_RESET;
            boot_req <= 1'b0;
        end else if (take_cmd) begin
            ptr_ext  <= `EXT_PTR_RESET;
            boot_req <= 1'b0;
        end else if (high_wr && subsystem_ready) begin
            boot_req <= reg_wdata[`EXT_BOOT_BIT];
            if (s_ext) begin
                ptr_ext <= reg_wdata[`EXT_PTR_MSB:`EXT_PTR_LSB];
            end
        end
    end

    // ****************************************
    // Internal address register
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dma_address <= `DMA_ADDR_RESET;
        end else if (take_cmd && boot_req) begin
            dma_address <= `BOOT_START_ADDR;
        end else if (take_cmd) begin
            dma_address <= {ptr_ext, reg_wdata[1:0], reg_wdata[15:2], 2'b00};
        end else if (high_wr && subsystem_ready && s_ext) begin
            dma_address[21:18] <= reg_wdata[`EXT_PTR_MSB:`EXT_PTR_LSB];
        end
    end

    // ****************************************
    // Write refused flag
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (rst || soft_init) begin
            write_refused <= 1'b0;
        end else if (low_wr && !subsystem_ready) begin
            write_refused <= 1'b1;
        end
    end

    // ****************************************
    // Sequencing and ready
    // ****************************************
    logic dep_done;

    always_ff @(posedge sys_clk) begin
        if (rst || soft_init) begin
            state           <= CTL_IDLE;
            subsystem_ready <= 1'b0;
            fetch_start     <= 1'b0;
            boot_start      <= 1'b0;
        end else begin
            fetch_start <= 1'b0;
            boot_start  <= 1'b0;
            unique case (state)
                CTL_IDLE: begin
                    if (take_cmd && boot_req) begin
                        state           <= CTL_BOOT;
                        subsystem_ready <= 1'b0;
                        boot_start      <= 1'b1;
                    end else if (take_cmd) begin
                        state           <= CTL_FETCH;
                        subsystem_ready <= 1'b0;
                        fetch_start     <= 1'b1;
                    end else if (diag_ok) begin
                        subsystem_ready <= 1'b1;
                    end
                end
                CTL_FETCH: begin
                    if (cmd_done) begin
                        state <= CTL_DEPOSIT;
                    end
                end
                CTL_DEPOSIT: begin
                    if (dep_done) begin
                        state           <= CTL_IDLE;
                        subsystem_ready <= 1'b1;
                    end
                end
                CTL_BOOT: begin
                    if (boot_done || boot_fail) begin
                        state           <= CTL_IDLE;
                        subsystem_ready <= 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            boot_length <= 10'h000;
        end else begin
            boot_length <= `BOOT_BYTES;
        end
    end

    // ****************************************
    // Tape position tracking
    // ****************************************
    logic prev_tm, since_bot, prev_bot, prev_onl, let_hit;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prev_tm   <= 1'b0;
            since_bot <= 1'b0;
            prev_bot  <= 1'b0;
        end else begin
            prev_bot <= s_bot;
            if (tm_detect) begin
                prev_tm <= 1'b1;
            end else if (rec_detect) begin
                prev_tm <= 1'b0;
            end
            if (prev_bot && !s_bot) begin
                since_bot <= 1'b1;
            end else if (tm_detect || rec_detect) begin
                since_bot <= 1'b0;
            end
        end
    end

    assign let_hit = let_enable && tm_detect && (prev_tm || since_bot);

    // ****************************************
    // Sticky event flags, cleared as a command is taken; volume check cleared by cvc_pulse
    // ****************************************
    logic f_tmk, f_rls, f_let, f_rll, f_eot, f_dlt, f_unc, f_vck;
    logic set_tmk, set_rls, set_rll, set_eot, set_dlt;

    assign set_tmk = (tm_detect && (cmd_kind == K_READ || cmd_kind == K_SPACE || cmd_kind == K_SKIP_TM))
                     || (cmd_done && cmd_kind == K_WTM);
    assign set_rls = (cmd_kind == K_READ && short_record)
                     || (cmd_kind == K_SPACE && count_left && (tm_detect || bot_hit))
                     || (cmd_kind == K_SKIP_TM && count_left
                         && (bot_hit || (double_mark_stop && tm_detect && prev_tm)));
    assign set_rll = cmd_kind == K_READ && long_record;
    assign set_eot = s_eot || (logical_end && (is_write_kind(cmd_kind) ? buf_empty : last_rec_req));
    assign set_dlt = (cmd_kind == K_READ && buf_full && drive_byte)
                     || (cmd_kind == K_WRITE && buf_empty && drive_req);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            {f_tmk, f_rls, f_let, f_rll, f_eot, f_dlt, f_unc} <= 7'h00;
        end else begin
            f_tmk <= set_tmk || (f_tmk && !take_cmd);
            f_rls <= set_rls || (f_rls && !take_cmd);
            f_let <= let_hit || (f_let && !take_cmd);
            f_rll <= set_rll || (f_rll && !take_cmd);
            f_eot <= set_eot || (f_eot && !take_cmd);
            f_dlt <= set_dlt || (f_dlt && !take_cmd);
            f_unc <= hard_error_evt || (f_unc && !take_cmd);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prev_onl <= 1'b0;
            f_vck    <= 1'b1;
        end else begin
            prev_onl <= s_onl;
            f_vck    <= (prev_onl && !s_onl) || (f_vck && !cvc_pulse);
        end
    end

    // ****************************************
    // Status word composition
    // ****************************************
    logic  write_protect_violation, cannot_execute, bad_address_flag, motion;
    word_t cond_w, err_w, info_w;

    assign motion = cmd_kind inside {K_READ, K_WRITE, K_WTM, K_SPACE, K_SKIP_TM, K_REWIND};
    assign write_protect_violation    = is_write_kind(cmd_kind) && s_wlk;
    assign cannot_execute    = (cmd_reverse && s_bot) || (motion && (f_vck || !s_onl))
                    || (!s_onl && cmd_kind != K_GET_STATUS && cmd_kind != K_DRV_INIT) || write_protect_violation;
    assign bad_address_flag    = (s_ext ? (|cmd_addr[23:22]) : (|cmd_addr[23:18]))
                    || (cmd_need_even && cmd_addr[0]);
    assign cond_w = {f_tmk, f_rls, f_let, f_rll, write_protect_violation, cannot_execute, cmd_bad_code, bad_address_flag,
                     s_busy || s_rew, s_onl, cmd_ie, f_vck, 1'b1, s_wlk, s_bot, f_eot};
    assign err_w  = {f_dlt, 13'h0000, f_unc, 1'b0};
    assign info_w = {s_busy, 7'h00,
                     (cmd_kind == K_WRCHAR || cmd_kind == K_GET_STATUS) ?
                     {s_ext, s_bufen, `UCODE_REV} : 8'h00};

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tape_condition_word <= `WORD_RESET;
            drive_error_word    <= `WORD_RESET;
            drive_info_word     <= `WORD_RESET;
        end else if (state == CTL_FETCH && cmd_done) begin
            tape_condition_word <= cond_w;
            drive_error_word    <= err_w;
            drive_info_word     <= info_w;
        end
    end

    // ****************************************
    // Message buffer deposit
    // ****************************************
    status_deposit u_dep (
        .sys_clk  (sys_clk),
        .rst      (rst || soft_init),
        .start    (state == CTL_FETCH && cmd_done),
        .w_cond   (cond_w),
        .w_err    (err_w),
        .w_info   (info_w),
        .msg_wr   (msg_wr),
        .msg_slot (msg_slot),
        .msg_data (msg_data),
        .done     (dep_done)
    );

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    high_needs_ready_a: assert property (high_wr && !subsystem_ready && !soft_init && !take_cmd
        |=> $stable(ptr_ext) && $stable(boot_req)) else $error("high byte changed while not ready");
    high_keeps_ready_a: assert property (high_wr && subsystem_ready && !soft_init && !low_wr
        |=> subsystem_ready) else $error("high byte write dropped ready");
    ext_to_addr_a: assert property (high_wr && subsystem_ready && s_ext && !soft_init && !low_wr
        |=> dma_address[21:18] == $past(reg_wdata[11:8])) else $error("extension not copied");
    ext_off_ignored_a: assert property (high_wr && subsystem_ready && !s_ext && !soft_init && !low_wr
        |=> $stable(ptr_ext)) else $error("extension taken with features off");
    low_clears_ext_a: assert property (take_cmd && !soft_init
        |=> ptr_ext == 4'h0 && !boot_req && !subsystem_ready) else $error("low word did not clear");
    init_clears_ext_a: assert property (bus_init |=> ptr_ext == 4'h0 && !boot_req)
        else $error("init left extension");
    refused_set_a: assert property (low_wr && !subsystem_ready && !soft_init |=> write_refused)
        else $error("refused flag missing");
    boot_holds_a: assert property (state == CTL_BOOT && !boot_done && !boot_fail && !soft_init
        |=> !subsystem_ready) else $error("ready during boot");
    boot_addr_a: assert property (take_cmd && boot_req && !soft_init
        |=> boot_start && dma_address == 22'h000000) else $error("boot not started at zero");
    deposit_seq_a: assert property (state == CTL_FETCH && cmd_done && !soft_init
        |=> msg_wr && msg_slot == 3'h4 ##1 msg_wr && msg_slot == 3'h5 ##1 msg_wr && msg_slot == 3'h6)
        else $error("status words out of order");
    fixed_bit_a: assert property (msg_wr && msg_slot == 3'h4 |-> msg_data[3])
        else $error("fixed bit not one");
    err_zero_a: assert property (msg_wr && msg_slot == 3'h5 |-> (msg_data & 16'h7ffd) == 16'h0000)
        else $error("unused error bits set");
    vck_set_a: assert property ($fell(s_onl) |=> f_vck) else $error("volume check not set");
    short_sticky_a: assert property (set_rls && !take_cmd |=> f_rls [*2] or take_cmd)
        else $error("short flag lost");

    cmd_cycle_c: cover property (take_cmd && !boot_req ##[1:50] dep_done);
    boot_cycle_c: cover property (take_cmd && boot_req ##[1:50] boot_done);
    refused_c: cover property (low_wr && !subsystem_ready);
    ext_load_c: cover property (high_wr && subsystem_ready && s_ext);
endmodule // tape_ptr_status

/* File: host_model.sv */
/* Host stand-in that writes the pointer registers on the register port.
   Assumes calls start just after a rising edge of sys_clk. */
`timescale 1ns/1ps
module host_model (
    input  wire logic          sys_clk,
    input  wire logic          write_refused,
    output logic               reg_wr,
    output logic               reg_byte,
    output logic               reg_byte_hi,
    output logic [1:0]         reg_addr,
    output tape_ptr_pkg::word_t reg_wdata
);
    import tape_ptr_pkg::*;
    logic refused_seen = 1'b0;
    initial {reg_wr, reg_byte, reg_byte_hi, reg_addr, reg_wdata} = '0;
    // High byte as a byte write, low word as a word write
    // One idle edge first, so back-to-back calls never drive reg_wr twice at once
    task automatic wr(input logic hi, input word_t d);
        @(posedge sys_clk);
        #1;
        reg_wr      = 1'b1;
        reg_byte    = hi;
        reg_byte_hi = hi;
        reg_addr    = hi ? 2'h2 : 2'h1;
        reg_wdata   = d;
        @(posedge sys_clk);
        #1;
        reg_wr    = 1'b0;
        reg_wdata = ~d;
        if (hi)
            refused_seen = write_refused;
    endtask
endmodule // host_model

/* File: tape_ptr_status_bench.sv */
/* Bench for tape_ptr_status: refusal, pointer, deposit and boot.
   Assumes the package, header, host_model and design compile first. */
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tape_ptr_status_bench;
    import tape_ptr_pkg::*;
    int miscompares = 0, cmp_count = 0;
    logic sys_clk = 0, rst = 1, bus_init = 0, diag_ok = 0, cmd_done = 0, boot_done = 0, boot_fail = 0;
    logic cmd_reverse = 0, cmd_bad_code = 0, cmd_need_even = 0, cmd_ie = 0, cvc_pulse = 0, let_enable = 0;
    logic double_mark_stop = 0, tm_detect = 0, rec_detect = 0, bot_hit = 0, short_record = 0, long_record = 0;
    logic count_left = 0, logical_end = 0, buf_full = 0, buf_empty = 0, drive_byte = 0, drive_req = 0;
    logic last_rec_req = 0, hard_error_evt = 0, drive_busy_pin = 1, rewinding_pin = 0, online_pin = 1;
    logic wr_protect_pin = 0, bot_pin = 0, eot_hole_pin = 0, ext_features_pin = 1, buf_enable_pin = 0;
    logic [23:0] cmd_addr = '0;
    cmd_kind_t cmd_kind = K_READ;
    logic reg_wr, reg_byte, reg_byte_hi, subsystem_ready, write_refused, fetch_start, boot_start, msg_wr;
    logic [1:0] reg_addr;
    logic [2:0] msg_slot;
    logic [9:0] boot_length;
    word_t reg_wdata, tape_condition_word, drive_error_word, drive_info_word, msg_data;
    bus_addr_t dma_address;
    always #5 sys_clk = ~sys_clk;
    host_model host_model_inst (.sys_clk, .write_refused, .reg_wr, .reg_byte, .reg_byte_hi, .reg_addr, .reg_wdata);
    tape_ptr_status tape_ptr_status_inst (.sys_clk, .rst, .bus_init, .reg_wr, .reg_byte, .reg_byte_hi, .reg_addr,
        .reg_wdata, .diag_ok, .cmd_done, .boot_done, .boot_fail, .cmd_kind, .cmd_reverse, .cmd_bad_code, .cmd_addr,
        .cmd_need_even, .cmd_ie, .cvc_pulse, .let_enable, .double_mark_stop, .tm_detect, .rec_detect, .bot_hit,
        .short_record, .long_record, .count_left, .logical_end, .buf_full, .buf_empty, .drive_byte, .drive_req,
        .last_rec_req, .hard_error_evt, .drive_busy_pin, .rewinding_pin, .online_pin, .wr_protect_pin, .bot_pin,
        .eot_hole_pin, .ext_features_pin, .buf_enable_pin, .subsystem_ready, .write_refused, .dma_address,
        .fetch_start, .boot_start, .boot_length, .tape_condition_word, .drive_error_word, .drive_info_word,
        .msg_wr, .msg_slot, .msg_data);
    task automatic tick(int n = 1);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic wait_ready();
        for (int i = 0; i < 20 && subsystem_ready !== 1'b1; i++)
            tick();
        if (subsystem_ready !== 1'b1) begin
            miscompares++;
            end_sim();
        end
    endtask
    task automatic refuse_then_ready();
        host_model_inst.wr(1'b0, 16'h1234);
        `CHK({write_refused, fetch_start}, 2'b10)
        host_model_inst.wr(1'b1, 16'h0f00);
        `CHK(dma_address[21:18], 4'h0)
        bus_init = 1;
        tick();
        bus_init = 0;
        `CHK(write_refused, 1'b0)
        diag_ok = 1;
        tick();
        diag_ok = 0;
        wait_ready();
    endtask
    task automatic fetch_and_deposit();
        host_model_inst.wr(1'b1, 16'h0a00);
        `CHK({dma_address[21:18], subsystem_ready, host_model_inst.refused_seen}, 6'h2a)
        host_model_inst.wr(1'b0, 16'h1235);
        `CHK(dma_address, {4'ha, 2'b01, 14'h048d, 2'b00})
        `CHK({fetch_start, subsystem_ready}, 2'b10)
        tm_detect = 1;
        hard_error_evt = 1;
        tick();
        {tm_detect, hard_error_evt} = 2'b00;
        cmd_done = 1;
        tick();
        cmd_done = 0;
        `CHK({msg_wr, msg_slot, msg_data[15], msg_data[3]}, 6'h33)
        tick();
        `CHK({msg_slot, msg_data}, {3'h5, 16'h0002})
        tick();
        `CHK({msg_slot, msg_data}, {3'h6, 16'h8000})
        `CHK({tape_condition_word, drive_error_word, drive_info_word}, 48'h84d8_0002_8000)
        wait_ready();
        host_model_inst.wr(1'b0, 16'h0100);
        `CHK(dma_address, 22'h000100)
        cmd_done = 1;
        tick();
        cmd_done = 0;
        wait_ready();
    endtask
    task automatic flags_cmd();
        host_model_inst.wr(1'b0, 16'h0200);
        {cmd_bad_code, cmd_need_even, buf_full, cvc_pulse} = 4'hf;
        cmd_addr = 24'h000001;
        {short_record, long_record, drive_byte} = 3'h7;
        tick();
        {short_record, long_record, drive_byte, cvc_pulse} = 4'h0;
        cmd_done = 1;
        tick();
        cmd_done = 0;
        `CHK(tape_condition_word, 16'h53c8)
        `CHK(drive_error_word, 16'h8000)
        {cmd_bad_code, cmd_need_even, buf_full} = 3'h0;
        cmd_addr = '0;
        wait_ready();
    endtask
    task automatic boot_ext_off();
        ext_features_pin = 0;
        tick(3);
        host_model_inst.wr(1'b1, 16'h8f00);
        `CHK(dma_address[21:18], 4'h0)
        host_model_inst.wr(1'b0, 16'h0000);
        `CHK({boot_start, fetch_start, dma_address, boot_length}, {2'b10, 22'h0, 10'h200})
        tick(3);
        `CHK(subsystem_ready, 1'b0)
        boot_done = 1;
        tick();
        boot_done = 0;
        wait_ready();
    endtask
    initial begin
        tick(8);
        rst = 0;
        tick(3);
        refuse_then_ready();
        fetch_and_deposit();
        flags_cmd();
        boot_ext_off();
        end_sim();
    end
endmodule // tape_ptr_status_bench
